//--- core/cfu_control_flow.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] mask branch: all masked bits set/clear
// [RULE2] mask branch offset signed 8-bit
// [RULE3] loop counter A,B,D,X,Y or SP
// [RULE4] loop offset signed 9-bit
// [RULE5] decrement loop writes back, branches zero/nonzero
// [RULE6] increment loop writes back, branches zero/nonzero
// [RULE7] test loop leaves counter, branches zero/nonzero
// [RULE8] jump loads absolute or indexed target
// [RULE9] subroutine entry: SP-2, push return high/low
// [RULE10] return pops PC high/low, SP+2
// [RULE11] paged call pushes return then page
// [RULE12] page immediate, or from memory indirect
// [RULE13] paged return pops page, then PC
// [RULE14] paged call/return always work fully
// [RULE15] untaken branch: PC after last operand
module cfu_control_flow (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire cfu_pkg::cfu_op_t  op,
	input  wire cfu_pkg::cfu_loop_t loopKind,
	input  wire logic              loopOnZero,
	input  wire cfu_pkg::cfu_cnt_t cntSel,
	input  wire logic [15:0]       nextPc,
	input  wire logic [7:0]        memByte,
	input  wire logic [7:0]        maskByte,
	input  wire logic [8:0]        offset,
	input  wire logic [15:0]       target,
	input  wire logic [7:0]        newPage,
	input  wire logic [7:0]        regA,
	input  wire logic [7:0]        regB,
	input  wire logic [15:0]       regX,
	input  wire logic [15:0]       regY,
	output logic                   busy,
	output logic                   done,
	output logic [15:0]            pc,
	output logic [15:0]            sp,
	output logic [7:0]             programPage,
	output logic                   cntWrite,
	output cfu_pkg::cfu_cnt_t      cntWrSel,
	output logic [15:0]            cntWrData,
	output logic                   memWrite,
	output logic                   memRead,
	output logic [15:0]            memAddr,
	output logic [7:0]             memWrData,
	input  wire logic [7:0]        memRdData
);
	import cfu_pkg::*;

	cfu_state_t  state_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;
	logic [7:0]  page_q;
	logic [15:0] ret_q;
	logic [7:0]  oldPage_q;
	logic [7:0]  pcHi_q;
	logic [15:0] counter;
	logic [15:0] cntNew;
	logic        cntZero;
	logic        maskTaken;
	logic        loopTaken;
	logic [15:0] br8Target;
	logic [15:0] br9Target;
	logic        isWide;
	cfu_op_t     op_q;

	// indexed-indirect call modes resolve page and address upstream
	// into newPage/target, so both modes look alike here
	always_comb begin
		case (cntSel)
			CN_A:    counter = {8'h00, regA};
			CN_B:    counter = {8'h00, regB};
			CN_D:    counter = {regA, regB};
			CN_X:    counter = regX;
			CN_Y:    counter = regY;
			CN_SP:   counter = sp_q;
			default: counter = 16'h0000;
		endcase
	end // RULE3

	assign isWide = cntSel[2];

	always_comb begin
		case (loopKind)
			LP_DEC:  cntNew = counter - STEP_ONE; // RULE5
			LP_INC:  cntNew = counter + STEP_ONE; // RULE6
			default: cntNew = counter; // RULE7
		endcase
	end

	// byte counters only test their low eight bits
	assign cntZero = isWide ? (cntNew == 16'h0000) : (cntNew[7:0] == 8'h00);
	assign loopTaken = (cntZero == loopOnZero); // RULE5 RULE6 RULE7

	assign maskTaken = (op == OP_BRSETM) ? ((~memByte & maskByte) == 8'h00)
		: ((memByte & maskByte) == 8'h00); // RULE1

	assign br8Target = nextPc + {{8{offset[7]}}, offset[7:0]}; // RULE2
	assign br9Target = nextPc + {{7{offset[8]}}, offset}; // RULE4

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						case (op)
							OP_SUBR, OP_CALLPG: state_q <= ST_WR_HI;
							OP_RETSUB:          state_q <= ST_RD_HI;
							OP_RETPG:           state_q <= ST_RD_PG;
							default:            state_q <= ST_DONE;
						endcase
					end
				end
				ST_WR_HI: state_q <= ST_WR_LO;
				ST_WR_LO: state_q <= (op_q == OP_CALLPG) ? ST_WR_PG : ST_DONE;
				ST_WR_PG: state_q <= ST_DONE;
				ST_RD_PG: state_q <= ST_RD_HI;
				ST_RD_HI: state_q <= ST_RD_LO;
				ST_RD_LO: state_q <= ST_DONE;
				ST_DONE:  state_q <= ST_IDLE;
				default:  state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ret_q     <= 16'h0000;
			oldPage_q <= PAGE_RESET;
			op_q      <= OP_NONE;
		end else if (state_q == ST_IDLE && start) begin
			// op is held here so the sequence never depends on the live input
			ret_q     <= nextPc;
			oldPage_q <= page_q;
			op_q      <= op;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pc_q   <= PC_RESET;
			pcHi_q <= 8'h00;
		end else if (state_q == ST_IDLE && start) begin
			case (op)
				OP_BRSETM, OP_BRCLRM: pc_q <= maskTaken ? br8Target : nextPc; // RULE1 RULE15
				OP_LOOP:   pc_q <= loopTaken ? br9Target : nextPc; // RULE15
				OP_JUMP:   pc_q <= target; // RULE8
				OP_SUBR, OP_CALLPG: pc_q <= target; // RULE9 RULE11
				default:   pc_q <= pc_q;
			endcase
		end else if (state_q == ST_RD_HI) begin
			pcHi_q <= memRdData; // RULE10 RULE13
		end else if (state_q == ST_RD_LO) begin
			pc_q <= {pcHi_q, memRdData}; // RULE10 RULE13
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sp_q <= SP_RESET;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start && (op == OP_SUBR || op == OP_CALLPG)) begin
						sp_q <= sp_q - STEP_TWO; // RULE9 RULE11
					end else if (start && op == OP_LOOP && cntSel == CN_SP) begin
						sp_q <= cntNew; // RULE5 RULE6
					end
				end
				ST_WR_LO: if (op_q == OP_CALLPG) sp_q <= sp_q - STEP_ONE; // RULE11
				ST_RD_PG: sp_q <= sp_q + STEP_ONE; // RULE13
				ST_RD_LO: sp_q <= sp_q + STEP_TWO; // RULE10 RULE13
				default:  sp_q <= sp_q;
			endcase
		end
	end

	// page register is always present so stacking works without paging
	always_ff @(posedge clock) begin
		if (rst) begin
			page_q <= PAGE_RESET;
		end else if (state_q == ST_IDLE && start && op == OP_CALLPG) begin
			page_q <= newPage; // RULE11 RULE12 RULE14
		end else if (state_q == ST_RD_PG) begin
			page_q <= memRdData; // RULE13 RULE14
		end
	end

	always_comb begin
		memWrite  = 1'b0;
		memRead   = 1'b0;
		memAddr   = sp_q;
		memWrData = 8'h00;
		case (state_q)
			ST_WR_HI: begin
				memWrite  = 1'b1;
				memWrData = ret_q[15:8]; // RULE9
			end
			ST_WR_LO: begin
				memWrite  = 1'b1;
				memAddr   = sp_q + STEP_ONE;
				memWrData = ret_q[7:0]; // RULE9
			end
			ST_WR_PG: begin
				memWrite  = 1'b1;
				memWrData = oldPage_q; // RULE11
			end
			ST_RD_PG: memRead = 1'b1;
			ST_RD_HI: memRead = 1'b1;
			ST_RD_LO: begin
				memRead = 1'b1;
				memAddr = sp_q + STEP_ONE;
			end
			default: memRead = 1'b0;
		endcase
	end

	always_comb begin
		cntWrite  = 1'b0;
		// byte counters go back with a clear high byte
		cntWrData = isWide ? cntNew : {8'h00, cntNew[7:0]};
		cntWrSel  = cntSel;
		if (state_q == ST_IDLE && start && op == OP_LOOP && loopKind != LP_TEST) begin
			cntWrite = 1'b1; // RULE5 RULE6
		end
	end

	assign busy        = (state_q != ST_IDLE);
	assign done        = (state_q == ST_DONE);
	assign pc          = pc_q;
	assign sp          = sp_q;
	assign programPage = page_q;

	chk_test_no_write: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_LOOP && loopKind == LP_TEST) |-> !cntWrite)
		else $error("test loop wrote its counter"); // RULE7
	chk_call_sp_drop: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_CALLPG) |=> ##2 (sp == $past(sp, 3) - 16'h0003))
		else $error("paged call stack drop wrong"); // RULE11
	chk_ret_sp_rise: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_RETSUB) |=> ##2 (sp == $past(sp, 3) + 16'h0002))
		else $error("return stack rise wrong"); // RULE10
	chk_retpg_sp_rise: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_RETPG) |=> ##3 (sp == $past(sp, 4) + 16'h0003))
		else $error("paged return stack rise wrong"); // RULE13
	chk_jump_target: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_JUMP) |=> (pc == $past(target)))
		else $error("jump target not loaded"); // RULE8
	chk_entry_push: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_SUBR) |=> (memWrite && memAddr == sp
		&& memWrData == $past(nextPc[15:8])) ##1 (memWrite && memWrData == $past(nextPc[7:0], 2)))
		else $error("return address push wrong"); // RULE9
	chk_mask_branch: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_BRSETM && (memByte & maskByte) != maskByte)
		|=> (pc == $past(nextPc)))
		else $error("mask branch taken wrongly"); // RULE1
	chk_loop_offset: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_LOOP && loopTaken)
		|=> (pc == $past(nextPc) + {{7{$past(offset[8])}}, $past(offset)}))
		else $error("loop branch target wrong"); // RULE4
	chk_call_page: assert property (@(posedge clock) disable iff (rst)
		(start && !busy && op == OP_CALLPG) |=> ##2 (memWrite && memWrData == $past(programPage, 3)))
		else $error("old page not stacked"); // RULE11

	chk_clr_branch: assert property (@(posedge clock) disable iff (rst) // RULE2
		(start && !busy && op == OP_BRCLRM && (memByte & maskByte) == 8'h00)
		|=> (pc == $past(nextPc) + {{8{$past(offset[7])}}, $past(offset[7:0])}))
		else $error("mask branch target wrong");
	chk_dec_write: assert property (@(posedge clock) disable iff (rst) // RULE5
		(start && !busy && op == OP_LOOP && loopKind == LP_DEC && cntSel == CN_X)
		|-> (cntWrite && cntWrData == regX - 16'h0001))
		else $error("decrement write back wrong");
	chk_inc_write: assert property (@(posedge clock) disable iff (rst) // RULE6
		(start && !busy && op == OP_LOOP && loopKind == LP_INC && cntSel == CN_Y)
		|-> (cntWrite && cntWrData == regY + 16'h0001))
		else $error("increment write back wrong");
	chk_loop_fall: assert property (@(posedge clock) disable iff (rst) // RULE15
		(start && !busy && op == OP_LOOP && loopKind == LP_TEST && loopOnZero
		&& cntSel == CN_Y && regY != 16'h0000) |=> (pc == $past(nextPc)))
		else $error("untaken loop moved pc wrongly");
	chk_sp_counter: assert property (@(posedge clock) disable iff (rst) // RULE3
		(start && !busy && op == OP_LOOP && loopKind == LP_DEC && cntSel == CN_SP)
		|=> (sp == $past(sp) - 16'h0001))
		else $error("stack pointer counter wrong");
	chk_ret_read: assert property (@(posedge clock) disable iff (rst) // RULE10
		(start && !busy && op == OP_RETSUB) |=> (memRead && memAddr == sp)
		##1 (memRead && memAddr == sp + 16'h0001))
		else $error("return read order wrong");
	chk_retpg_read: assert property (@(posedge clock) disable iff (rst) // RULE13
		(start && !busy && op == OP_RETPG) |=> (memRead && memAddr == sp)
		##1 (memRead && memAddr == sp) ##1 (memRead && memAddr == sp + 16'h0001))
		else $error("paged return read order wrong");
	chk_new_page: assert property (@(posedge clock) disable iff (rst) // RULE12
		(start && !busy && op == OP_CALLPG) |=> (programPage == $past(newPage)))
		else $error("new page not loaded");
	chk_paged_target: assert property (@(posedge clock) disable iff (rst) // RULE14
		(start && !busy && (op == OP_CALLPG || op == OP_SUBR)) |=> (pc == $past(target)))
		else $error("call target not loaded");
endmodule : cfu_control_flow

//--- core/cfu_pkg.sv
package cfu_pkg;
	typedef enum logic [3:0] {
		OP_NONE      = 4'b0000,
		OP_BRSETM    = 4'b0001,
		OP_BRCLRM    = 4'b0010,
		OP_LOOP      = 4'b0011,
		OP_JUMP      = 4'b0100,
		OP_SUBR      = 4'b0101,
		OP_RETSUB    = 4'b0110,
		OP_CALLPG    = 4'b0111,
		OP_RETPG     = 4'b1000
	} cfu_op_t;

	typedef enum logic [1:0] {
		LP_DEC  = 2'b00,
		LP_INC  = 2'b01,
		LP_TEST = 2'b10
	} cfu_loop_t;

	typedef enum logic [2:0] {
		CN_A  = 3'b000,
		CN_B  = 3'b001,
		CN_D  = 3'b100,
		CN_X  = 3'b101,
		CN_Y  = 3'b110,
		CN_SP = 3'b111
	} cfu_cnt_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WR_HI = 3'b001,
		ST_WR_LO = 3'b010,
		ST_WR_PG = 3'b011,
		ST_RD_PG = 3'b100,
		ST_RD_HI = 3'b101,
		ST_RD_LO = 3'b110,
		ST_DONE  = 3'b111
	} cfu_state_t;

	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [15:0] SP_RESET   = 16'h0000;
	localparam logic [7:0]  PAGE_RESET = 8'h00;
	localparam logic [15:0] STEP_ONE   = 16'h0001;
	localparam logic [15:0] STEP_TWO   = 16'h0002;
endpackage : cfu_pkg

//--- tb/cfu_stack_mem.sv
`timescale 1ns/1ps
module cfu_stack_mem (
	input  wire logic        clock,
	input  wire logic        memWrite,
	input  wire logic        memRead,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	output logic [7:0]       memRdData
);
	logic [7:0] mem [0:255];
	// only the low address byte decodes; stack tests stay inside one 256-byte window
	always_ff @(posedge clock) begin
		if (memWrite) begin
			mem[memAddr[7:0]] <= memWrData;
		end
	end
	// undriven bus shows the inverse so a stale read cannot pass by luck
	assign memRdData = memRead ? mem[memAddr[7:0]] : ~mem[memAddr[7:0]];
endmodule : cfu_stack_mem

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cfu_pkg::*;
	logic clock = 0, rst = 1, start = 0, loopOnZero = 0;
	cfu_op_t op = OP_NONE;
	cfu_loop_t loopKind = LP_DEC;
	cfu_cnt_t cntSel = CN_A;
	logic [15:0] nextPc = 16'h4000, target = 16'h0000, regX = 16'h0000, regY = 16'h0000;
	logic [7:0] memByte = 8'h00, maskByte = 8'h00, newPage = 8'h00, regA = 8'h00, regB = 8'h00;
	logic [8:0] offset = 9'h000;
	logic busy, done, cntWrite, memWrite, memRead, wr;
	logic [15:0] pc, sp, cntWrData, memAddr, wd;
	logic [7:0] programPage, memWrData, memRdData;
	cfu_cnt_t cntWrSel;
	int mismatches = 0, tests_run = 0;
	cfu_control_flow i_cfu_control_flow (.clock, .rst, .start, .op, .loopKind, .loopOnZero,
		.cntSel, .nextPc, .memByte, .maskByte, .offset, .target, .newPage, .regA, .regB,
		.regX, .regY, .busy, .done, .pc, .sp, .programPage, .cntWrite, .cntWrSel,
		.cntWrData, .memWrite, .memRead, .memAddr, .memWrData, .memRdData);
	cfu_stack_mem i_cfu_stack_mem (.clock, .memWrite, .memRead, .memAddr, .memWrData,
		.memRdData);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// start is sampled one edge later; counter write strobe is looked at in the start cycle
	task automatic run(input cfu_op_t o);
		int n = 0;
		@(posedge clock);
		#1 op = o;
		start = 1;
		#1 wr = cntWrite;
		wd = cntWrData;
		@(posedge clock);
		#1 start = 0;
		while (done !== 1'b1 && n < 10) begin
			@(posedge clock);
			#1 n++;
		end
		chk("done", 16'h0001, {15'h0000, done});
		chk("busy", 16'h0001, {15'h0000, busy});
	endtask : run
	task automatic lp(input cfu_loop_t k, input logic z, input cfu_cnt_t c,
		input logic [15:0] ew, input logic tk);
		loopKind = k;
		loopOnZero = z;
		cntSel = c;
		run(OP_LOOP);
		chk("cntWrite", {15'h0000, k != LP_TEST}, {15'h0000, wr});
		chk("cntWrSel", {13'h0000, c}, {13'h0000, cntWrSel});
		if (k != LP_TEST && c != CN_SP) chk("cntWrData", ew, wd);
		chk("pc", tk ? nextPc + {{7{offset[8]}}, offset} : nextPc, pc);
	endtask : lp
	task automatic t_mask;
		memByte = 8'hF0;
		maskByte = 8'h30;
		offset = 9'h080;
		run(OP_BRSETM);
		chk("pc", nextPc - 16'h0080, pc);
		run(OP_BRCLRM);
		chk("pc", nextPc, pc);
		memByte = 8'h0F;
		run(OP_BRCLRM);
		chk("pc", nextPc - 16'h0080, pc);
		$display("mask branch test done");
	endtask : t_mask
	task automatic t_loop;
		offset = 9'h100;
		regA = 8'h01;
		lp(LP_DEC, 1'b1, CN_A, 16'h0000, 1'b1);
		regA = 8'h00;
		regB = 8'h01;
		lp(LP_DEC, 1'b0, CN_D, 16'h0000, 1'b0);
		regX = 16'hFFFF;
		lp(LP_INC, 1'b0, CN_X, 16'h0000, 1'b0);
		regB = 8'hFF;
		lp(LP_INC, 1'b1, CN_B, 16'h0000, 1'b1);
		offset = 9'h0FF;
		regY = 16'h0005;
		lp(LP_TEST, 1'b0, CN_Y, 16'h0000, 1'b1);
		lp(LP_TEST, 1'b1, CN_Y, 16'h0000, 1'b0);
		lp(LP_DEC, 1'b0, CN_SP, 16'h0000, 1'b1);
		chk("sp", 16'hFFFF, sp);
		lp(LP_INC, 1'b1, CN_SP, 16'h0000, 1'b1);
		chk("sp", 16'h0000, sp);
		$display("loop test done");
	endtask : t_loop
	task automatic t_sub;
		target = 16'h1234;
		run(OP_JUMP);
		chk("pc", 16'h1234, pc);
		nextPc = 16'hABCD;
		target = 16'h2468;
		run(OP_SUBR);
		chk("sp", 16'hFFFE, sp);
		chk("hi", 16'h00AB, {8'h00, i_cfu_stack_mem.mem[8'hFE]});
		chk("lo", 16'h00CD, {8'h00, i_cfu_stack_mem.mem[8'hFF]});
		chk("pc", 16'h2468, pc);
		run(OP_RETSUB);
		chk("pc", 16'hABCD, pc);
		chk("sp", 16'h0000, sp);
		$display("subroutine test done");
	endtask : t_sub
	task automatic t_paged;
		nextPc = 16'h5678;
		target = 16'h8000;
		newPage = 8'h5A;
		run(OP_CALLPG);
		chk("sp", 16'hFFFD, sp);
		chk("old page", 16'h0000, {8'h00, i_cfu_stack_mem.mem[8'hFD]});
		chk("hi", 16'h0056, {8'h00, i_cfu_stack_mem.mem[8'hFE]});
		chk("page", 16'h005A, {8'h00, programPage});
		chk("pc", 16'h8000, pc);
		chk("lo", 16'h0078, {8'h00, i_cfu_stack_mem.mem[8'hFF]});
		nextPc = 16'h9ABC;
		newPage = 8'hA5;
		run(OP_CALLPG);
		chk("old page", 16'h005A, {8'h00, i_cfu_stack_mem.mem[8'hFA]});
		chk("page", 16'h00A5, {8'h00, programPage});
		chk("sp", 16'hFFFA, sp);
		run(OP_RETPG);
		chk("page", 16'h005A, {8'h00, programPage});
		chk("pc", 16'h9ABC, pc);
		chk("sp", 16'hFFFD, sp);
		run(OP_RETPG);
		chk("page", 16'h0000, {8'h00, programPage});
		chk("pc", 16'h5678, pc);
		chk("sp", 16'h0000, sp);
		$display("paged call test done");
	endtask : t_paged
	initial begin
		repeat (8) @(posedge clock);
		#1 rst = 0;
		chk("pc", PC_RESET, pc);
		t_mask();
		t_loop();
		t_sub();
		t_paged();
		stop_test();
	end
	// all tests need well under 300 cycles
	initial begin
		#20000;
		mismatches++;
		stop_test();
	end
endmodule : tb_top
